//--- include/nvm_pkg.sv
package nvm_pkg;

  // Array geometry: 1 Kbit held as bytes
  localparam int MEM_AW = 7;
  localparam int MEM_DW = 8;
  localparam int MEM_DEPTH = 128;
  localparam logic [6:0] MEM_LAST = 7'h7F;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // Opcodes following the lead marker bit
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;

  // Sub-commands carried in the two top address bits of opcode 00
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_FILL_ALL = 2'h1;
  localparam logic [1:0] SUB_CLEAR_ALL = 2'h2;
  localparam logic [1:0] SUB_ENABLE = 2'h3;

  // Field lengths per organisation
  localparam logic [4:0] ADDR_BITS_X8 = 5'h07;
  localparam logic [4:0] ADDR_BITS_X16 = 5'h06;
  localparam logic [4:0] DATA_BITS_X8 = 5'h08;
  localparam logic [4:0] DATA_BITS_X16 = 5'h10;
  localparam logic [4:0] OPC_LAST = 5'h01;

  // Self-timed programming cycle
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned PROG_TIME_US = 3000;
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * (CLK_HZ / 1_000_000);

  // Wishbone register map (byte addresses) and fields
  localparam logic [3:0] CFG_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam int CFG_ORG_BIT = 0;
  localparam logic CFG_ORG_RESET = 1'b1;
  localparam int STAT_EN_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_SHOW_BIT = 2;

  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_SKIP} ser_state_t;

  // Address field length: org high selects word organisation
  function automatic logic [4:0] addr_bits(input logic word_size_select);
    return word_size_select ? ADDR_BITS_X16 : ADDR_BITS_X8;
  endfunction

  function automatic logic [4:0] data_bits(input logic word_size_select);
    return word_size_select ? DATA_BITS_X16 : DATA_BITS_X8;
  endfunction

  // Sub-command bits sit at the top of whichever address field is in use
  function automatic logic [1:0] sub_code(input logic [6:0] a, input logic word_size_select);
    return word_size_select ? a[5:4] : a[6:5];
  endfunction

  // Byte index of a location; in word mode lo picks the low byte
  function automatic logic [6:0] byte_idx(input logic [6:0] a, input logic word_size_select, input logic lo);
    return word_size_select ? {a[5:0], lo} : a;
  endfunction

endpackage

//--- hw/level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync
  import nvm_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // Two flops; only the second one is visible outside
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule
`default_nettype wire

//--- hw/nvm_array.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_array
  import nvm_pkg::*;
(
  // Clock
  input  wire logic              clock,
  // Write port
  input  wire logic              we,
  input  wire logic [MEM_AW-1:0] waddr,
  input  wire logic [MEM_DW-1:0] wdata,
  // Registered read port
  input  wire logic [MEM_AW-1:0] raddr,
  output logic      [MEM_DW-1:0] rdata_r
);

  logic [MEM_DW-1:0] mem [MEM_DEPTH];

  // No reset: contents are whatever the last programming left
  always_ff @(posedge clock)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata_r <= mem[raddr];
  end

endmodule
`default_nettype wire

//--- hw/serial_eeprom_program_control.sv
// Overview of operation
// (RL1) Instruction: select rises, lead bit one, two-bit opcode, address on serial_in.
// (RL2) Opcodes 10 read, 01 write, 11 erase; 00 uses top address bits.
// (RL3) Address is seven bits byte mode, six bits word mode; data 8 or 16.
// (RL4) Host always sends the don't-care address bits of opcode-00 commands.
// (RL5) After power-up programming is disabled.
// (RL6) Enable command must precede erase, write, fill-all and clear-all.
// (RL7) Enable persists until disable command or power loss.
// (RL8) Disable command blocks every programming command from changing the array.
// (RL9) Host should disable programming after finishing.
// (RL10) Read works whether programming is enabled or not.
// (RL11) Erase sets every bit of the addressed location to one.
// (RL12) Erase cycle starts once opcode and address are decoded.
// (RL13) Write carries 8 or 16 data bits after the address, MSB first.
// (RL14) Write cycle starts right after the last data bit arrives.
// (RL15) Select raised during programming shows ready/busy on serial_out.
// (RL16) Shown status is low while the cycle runs.
// (RL17) Status goes high once an erase has finished.
// (RL18) Status goes high once a write has finished.
// (RL19) Select raised after the cycle ended shows no status.
// (RL20) Fill-all programs every location with the command's data pattern.
// (RL21) Clear-all sets the whole array to ones, self-timed with status.
// (RL22) Programming commands while disabled are ignored: no change, no busy.
// (RL23) Cycle length is a parameter; no new programming until it ends.
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_program_control
  import nvm_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
)
(
  // System
  input  wire logic        clock,
  input  wire logic        nrst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Three-wire serial link
  input  wire logic        select_in,
  input  wire logic        serial_clock_in,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_en
);

  logic        rst_meta_r;
  logic        rst_n;
  logic        cs_s;
  logic        sk_s;
  logic        di_s;
  logic        cs_d_r;
  logic        sk_d_r;
  logic        sk_rise;
  logic        cs_rise;
  ser_state_t  state_r;
  ser_state_t  state_nxt;
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_nxt;
  logic [4:0]  rd_cnt_r;
  logic [4:0]  rd_cnt_nxt;
  logic [1:0]  opc_r;
  logic [1:0]  opc_nxt;
  logic [6:0]  addr_r;
  logic [6:0]  addr_nxt;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic        en_r;
  logic        en_nxt;
  logic        start_prog;
  logic        start_all;
  logic        start_erase;
  logic        status_r;
  logic        status_nxt;
  logic        out_r;
  logic        out_nxt;
  logic        oe_r;
  logic        oe_nxt;
  logic        busy_r;
  logic        busy_nxt;
  logic        wr_r;
  logic        wr_nxt;
  logic [31:0] pc_r;
  logic [31:0] pc_nxt;
  logic [6:0]  ptr_r;
  logic [6:0]  ptr_nxt;
  logic [6:0]  last_r;
  logic [6:0]  last_nxt;
  logic [15:0] wdata_r;
  logic [15:0] wdata_nxt;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic [6:0]  mem_raddr;
  logic        org_r;
  logic        org_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic        req;

  // Reset release through two flops; assertion is immediate
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Pins come from the host's timing, so they are synchronised first
  level_sync #(.W(3)) u_pin_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({select_in, serial_clock_in, serial_in}),
    .q     ({cs_s, sk_s, di_s})
  );

  nvm_array u_array (
    .clock   (clock),
    .we      (wr_r),
    .waddr   (ptr_r),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata_r (mem_rdata)
  );

  // Edge detection on the synchronised copies only
  assign sk_rise = sk_s & ~sk_d_r;
  assign cs_rise = cs_s & ~cs_d_r;
  assign mem_raddr = byte_idx(addr_r, org_r, rd_cnt_r[3]);

  // Instruction decoder: shifts on each rising serial clock while selected
  always_comb
  begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    rd_cnt_nxt  = rd_cnt_r;
    opc_nxt     = opc_r;
    addr_nxt    = addr_r;
    shift_nxt   = shift_r;
    en_nxt      = en_r;
    start_prog  = 1'b0;
    start_all   = 1'b0;
    start_erase = 1'b0;
    if (!cs_s)
      state_nxt = ST_IDLE;
    else if (sk_rise)
    begin
      case (state_r)
        ST_IDLE:
          if (di_s && !busy_r) // [RL1] [RL23]
          begin
            state_nxt = ST_OPC;
            cnt_nxt   = 5'h00;
            addr_nxt  = 7'h00;
          end
        ST_OPC:
        begin
          opc_nxt = {opc_r[0], di_s};
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == OPC_LAST)
          begin
            state_nxt = ST_ADDR;
            cnt_nxt   = 5'h00;
          end
        end
        ST_ADDR:
        begin
          addr_nxt = {addr_r[5:0], di_s};
          cnt_nxt  = cnt_r + 5'h01;
          // Full field always counted, don't-care bits included [RL3] [RL4]
          if (cnt_r == addr_bits(org_r) - 5'h01)
          begin
            cnt_nxt   = 5'h00;
            state_nxt = ST_SKIP;
            case (opc_r) // [RL2]
              OP_READ:
              begin
                state_nxt  = ST_READ; // [RL10]
                rd_cnt_nxt = 5'h00;
              end
              OP_WRITE:
                state_nxt = ST_DATA;
              OP_ERASE:
              begin
                start_prog  = en_r; // [RL12] [RL22]
                start_erase = 1'b1;
              end
              default:
                case (sub_code(addr_nxt, org_r))
                  SUB_ENABLE:    en_nxt = 1'b1; // [RL6] [RL7]
                  SUB_DISABLE:   en_nxt = 1'b0; // [RL8]
                  SUB_FILL_ALL:  state_nxt = ST_DATA;
                  SUB_CLEAR_ALL:
                  begin
                    start_prog  = en_r; // [RL21] [RL22]
                    start_all   = 1'b1;
                    start_erase = 1'b1;
                  end
                  default: ;
                endcase
            endcase
          end
        end
        ST_DATA:
        begin
          shift_nxt = {shift_r[14:0], di_s}; // [RL13]
          cnt_nxt   = cnt_r + 5'h01;
          if (cnt_r == data_bits(org_r) - 5'h01)
          begin
            start_prog = en_r; // [RL14] [RL20] [RL22]
            start_all  = (opc_r == OP_SPECIAL);
            state_nxt  = ST_SKIP;
          end
        end
        ST_READ:
          if (rd_cnt_r != data_bits(org_r))
            rd_cnt_nxt = rd_cnt_r + 5'h01;
        default: ;
      endcase
    end
  end

  // Self-timed programming: bytes are written first, then the timer runs out
  always_comb
  begin
    busy_nxt  = busy_r;
    wr_nxt    = wr_r;
    pc_nxt    = pc_r;
    ptr_nxt   = ptr_r;
    last_nxt  = last_r;
    wdata_nxt = wdata_r;
    mem_wdata = (org_r && !ptr_r[0]) ? wdata_r[15:8] : wdata_r[7:0];
    if (busy_r)
    begin
      pc_nxt = pc_r + 32'h1;
      if (pc_r == PROG_CYCLES_P - 32'h1) // [RL23]
        busy_nxt = 1'b0;
    end
    if (wr_r)
    begin
      if (ptr_r == last_r)
        wr_nxt = 1'b0;
      else
        ptr_nxt = ptr_r + 7'h01;
    end
    if (start_prog)
    begin
      busy_nxt  = 1'b1;
      wr_nxt    = 1'b1;
      pc_nxt    = 32'h0;
      ptr_nxt   = start_all ? 7'h00 : byte_idx(addr_nxt, org_r, 1'b0); // [RL20]
      last_nxt  = start_all ? MEM_LAST : byte_idx(addr_nxt, org_r, org_r);
      wdata_nxt = start_erase ? ERASED_WORD : shift_nxt; // [RL11] [RL21]
    end
  end

  // Serial output: ready/busy status wins over read data
  always_comb
  begin
    status_nxt = status_r;
    out_nxt    = out_r;
    oe_nxt     = 1'b0;
    if (!cs_s)
      status_nxt = 1'b0;
    else if (cs_rise && busy_r) // [RL15] [RL19]
      status_nxt = 1'b1;
    else if (sk_rise && di_s && !busy_r && state_r == ST_IDLE)
      status_nxt = 1'b0;
    if (status_nxt)
    begin
      oe_nxt  = 1'b1;
      out_nxt = !busy_nxt; // [RL16] [RL17] [RL18]
    end
    else if (state_nxt == ST_READ)
    begin
      oe_nxt = 1'b1;
      // Dummy zero first, then data MSB first on each rising edge
      if (sk_rise)
        out_nxt = (state_r == ST_READ && rd_cnt_r != data_bits(org_r)) ?
                  mem_rdata[3'h7 - rd_cnt_r[2:0]] : 1'b0;
    end
  end

  // Wishbone slave: ack one cycle after request, dropped the next
  always_comb
  begin
    req     = wb_cyc_i & wb_stb_i;
    ack_nxt = req & !ack_r;
    dat_nxt = dat_r;
    org_nxt = org_r;
    if (ack_nxt)
    begin
      dat_nxt = 32'h0;
      case (wb_adr_i)
        CFG_ADDR:    dat_nxt[CFG_ORG_BIT] = org_r;
        STATUS_ADDR:
        begin
          dat_nxt[STAT_EN_BIT]   = en_r;
          dat_nxt[STAT_BUSY_BIT] = busy_r;
          dat_nxt[STAT_SHOW_BIT] = status_r;
        end
        default: ;
      endcase
    end
    // Write lands on the edge where the master sees ack
    if (req && ack_r && wb_we_i && wb_sel_i[0] && wb_adr_i == CFG_ADDR)
      org_nxt = wb_dat_i[CFG_ORG_BIT];
  end

  // State registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_d_r   <= 1'b0;
      sk_d_r   <= 1'b0;
      state_r  <= ST_IDLE;
      cnt_r    <= 5'h00;
      rd_cnt_r <= 5'h00;
      opc_r    <= 2'h0;
      addr_r   <= 7'h00;
      shift_r  <= 16'h0000;
      en_r     <= 1'b0; // [RL5]
      status_r <= 1'b0;
      out_r    <= 1'b0;
      oe_r     <= 1'b0;
      busy_r   <= 1'b0;
      wr_r     <= 1'b0;
      pc_r     <= 32'h0;
      ptr_r    <= 7'h00;
      last_r   <= 7'h00;
      wdata_r  <= 16'h0000;
      org_r    <= CFG_ORG_RESET;
      ack_r    <= 1'b0;
      dat_r    <= 32'h0;
    end
    else
    begin
      cs_d_r   <= cs_s;
      sk_d_r   <= sk_s;
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      rd_cnt_r <= rd_cnt_nxt;
      opc_r    <= opc_nxt;
      addr_r   <= addr_nxt;
      shift_r  <= shift_nxt;
      en_r     <= en_nxt;
      status_r <= status_nxt;
      out_r    <= out_nxt;
      oe_r     <= oe_nxt;
      busy_r   <= busy_nxt;
      wr_r     <= wr_nxt;
      pc_r     <= pc_nxt;
      ptr_r    <= ptr_nxt;
      last_r   <= last_nxt;
      wdata_r  <= wdata_nxt;
      org_r    <= org_nxt;
      ack_r    <= ack_nxt;
      dat_r    <= dat_nxt;
    end
  end

  assign serial_out    = out_r;
  assign serial_out_en = oe_r;
  assign wb_ack_o      = ack_r;
  assign wb_dat_o      = dat_r;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence prog_begin_s;
    start_prog;
  endsequence
  sequence prog_hold_s;
    busy_r [*8];
  endsequence
  sequence erase_decode_s;
    state_r == ST_ADDR && cs_s && sk_rise && opc_r == OP_ERASE &&
    cnt_r == addr_bits(org_r) - 5'h01 && en_r;
  endsequence
  sequence data_last_s;
    state_r == ST_DATA && cs_s && sk_rise && cnt_r == data_bits(org_r) - 5'h01 && en_r;
  endsequence

  power_up_off_a: assert property ($rose(rst_n) |-> !en_r) // [RL5]
    else $error("programming enabled after reset");
  disabled_quiet_a: assert property (!en_r && !busy_r |=> !busy_r && !wr_r) // [RL8] [RL22]
    else $error("programming started while disabled");
  enable_hold_a: assert property (en_r && !(state_r == ST_ADDR && opc_r == OP_SPECIAL)
    |=> en_r) // [RL7]
    else $error("enable lost without a disable command");
  cycle_length_a: assert property (prog_begin_s |=> prog_hold_s) // [RL23]
    else $error("programming cycle ended too early");
  no_restart_a: assert property (busy_r |-> !start_prog) // [RL23]
    else $error("programming restarted while busy");
  erase_ones_a: assert property (start_prog && start_erase |=> wdata_r == ERASED_WORD) // [RL11]
    else $error("erase pattern not all ones");
  erase_start_a: assert property (erase_decode_s |=> busy_r && wr_r) // [RL12]
    else $error("erase did not start after decode");
  write_start_a: assert property (data_last_s |=> busy_r && wr_r) // [RL14]
    else $error("write did not start after last data bit");
  busy_low_a: assert property (status_r && busy_r |-> serial_out_en && !serial_out) // [RL16]
    else $error("busy status not low");
  ready_high_a: assert property (status_r && $fell(busy_r) |-> serial_out_en && serial_out) // [RL17]
    else $error("ready status not high after cycle");
  late_select_a: assert property ($rose(cs_s) && !busy_r |=> !status_r) // [RL19]
    else $error("status shown after cycle ended");
  read_any_a: assert property (state_r == ST_ADDR && cs_s && sk_rise && opc_r == OP_READ &&
    cnt_r == addr_bits(org_r) - 5'h01 |=> state_r == ST_READ && serial_out_en) // [RL10]
    else $error("read not started");

endmodule
`default_nettype wire

//--- test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // System clock paces every serial edge
  input  wire logic clock,
  // Device side of the link
  input  wire logic serial_out,
  input  wire logic serial_out_en,
  // Host driven pins
  output logic      select_in,
  output logic      serial_clock_in,
  output logic      serial_in
);
  // Serial clock rests low outside frames, except when poll drops select right after a command
  initial
  begin
    select_in = 1'b0;
    serial_clock_in = 1'b0;
    serial_in = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // A fresh rising select after a low gap opens each frame
  task automatic open_frame();
    select_in <= 1'b0;
    tick(8);
    select_in <= 1'b1;
    tick(4);
  endtask

  // Data toggled on release so a stale level never reads as a bit
  task automatic close_frame();
    serial_clock_in <= 1'b0;
    select_in <= 1'b0;
    serial_in <= ~serial_in;
    tick(8);
  endtask

  // MSB first, data moved while clock low; every bit of a field is sent
  task automatic shift(input logic [31:0] v, input int n, output logic [31:0] got);
    got = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in <= v[i];
      serial_clock_in <= 1'b0;
      tick(3);
      got = {got[30:0], serial_out};
      tick(1);
      serial_clock_in <= 1'b1;
      tick(4);
    end
  endtask

  // Ready/busy poll: select low then high, wait bounded for ready
  task automatic poll(output logic en, output logic first, output int waitc);
    select_in <= 1'b0;
    tick(8);
    select_in <= 1'b1;
    tick(6);
    en = serial_out_en;
    first = serial_out;
    waitc = 0;
    while (en === 1'b1 && serial_out !== 1'b1 && waitc < 400)
    begin
      tick(1);
      waitc++;
    end
    close_frame();
  endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nvm_pkg::*;
  localparam int P = 200;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        sel_pin;
  logic        sclk;
  logic        sdi;
  logic        sdo;
  logic        sdo_en;
  logic [31:0] rng = 32'h00014E39;
  logic [7:0]  mem [128];
  logic        word_size_select = 1'b1;
  logic        en_exp = 1'b0;
  int          miscompares = 0;
  int          compares = 0;

  serial_eeprom_program_control #(.PROG_CYCLES_P(P)) dut (
    .clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .select_in(sel_pin), .serial_clock_in(sclk), .serial_in(sdi),
    .serial_out(sdo), .serial_out_en(sdo_en));
  host_model host (.clock(clock), .serial_out(sdo), .serial_out_en(sdo_en),
    .select_in(sel_pin), .serial_clock_in(sclk), .serial_in(sdi));

  // 25 MHz system clock
  always #20 clock = ~clock;

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Word mode pairs bytes 2a (high) and 2a+1 (low)
  function automatic logic [15:0] exp_word(input logic [6:0] a);
    return word_size_select ? {mem[{a[5:0], 1'b0}], mem[{a[5:0], 1'b1}]} : {8'h00, mem[a]};
  endfunction

  task automatic check_val(input string name, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_cnt(input string name, input int lo, input int hi, input int g);
    compares++;
    if (g < lo || g > hi)
    begin
      miscompares++;
      $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, g);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  // No own limit: a missing ack is caught by the watchdog
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge clock);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Start bit, opcode, address of the current width, optional data
  task automatic cmd(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d,
                     input bit dat);
    int na;
    int nd;
    logic [31:0] v;
    logic [31:0] g;
    na = word_size_select ? 6 : 7;
    nd = word_size_select ? 16 : 8;
    v = {29'h0, 1'b1, op};
    v = (v << na) | (32'(a) & ((32'h1 << na) - 1));
    if (dat)
      v = (v << nd) | (32'(d) & ((32'h1 << nd) - 1));
    host.open_frame();
    host.shift(v, 3 + na + (dat ? nd : 0), g);
  endtask

  // Expected array and enable state
  task automatic apply(input logic [1:0] op, input logic [1:0] sub, input logic [6:0] a,
                       input logic [15:0] d);
    logic [6:0] i;
    i = word_size_select ? {a[5:0], 1'b0} : a;
    if (op == OP_SPECIAL && sub == SUB_ENABLE)
      en_exp = 1'b1;
    else if (op == OP_SPECIAL && sub == SUB_DISABLE)
      en_exp = 1'b0;
    else if (!en_exp)
      return;
    else if (op == OP_SPECIAL)
      for (int k = 0; k < 128; k++)
        mem[k] = (sub == SUB_CLEAR_ALL) ? 8'hFF : (word_size_select && !k[0]) ? d[15:8] : d[7:0];
    else
    begin
      if (op == OP_ERASE)
        d = 16'hFFFF;
      mem[i] = word_size_select ? d[15:8] : d[7:0];
      if (word_size_select)
        mem[i + 7'h01] = d[7:0];
    end
  endtask

  task automatic run(input logic [1:0] op, input logic [1:0] sub, input logic [6:0] a0,
                     input logic [15:0] d, input int lo);
    logic [6:0] a;
    logic en;
    logic first;
    int w;
    bit prog;
    a = (op != OP_SPECIAL) ? a0 : (word_size_select ? {1'b0, sub, a0[3:0]} : {sub, a0[4:0]});
    prog = op != OP_SPECIAL || sub == SUB_FILL_ALL || sub == SUB_CLEAR_ALL;
    cmd(op, a, d, op == OP_WRITE || (op == OP_SPECIAL && sub == SUB_FILL_ALL));
    if (!prog)
      host.close_frame();
    else
    begin
      host.poll(en, first, w);
      check_val("status shown", {31'h0, en_exp}, {31'h0, en});
      if (en_exp)
      begin
        check_val("status busy", 32'h0, {31'h0, first});
        check_cnt("busy cycles", lo, P, w);
      end
    end
    apply(op, sub, a, d);
  endtask

  task automatic rd(input logic [6:0] a);
    int nd;
    logic [31:0] g;
    nd = word_size_select ? 16 : 8;
    cmd(OP_READ, a, 16'h0, 1'b0);
    host.shift(32'h0, nd + 1, g);
    host.close_frame();
    check_val("read data", 32'(exp_word(a)), g & ((32'h1 << (nd + 1)) - 1));
  endtask

  // Main sequence
  initial
  begin
    logic [31:0] q;
    logic [6:0] a;
    logic [15:0] d;
    logic en;
    logic first;
    int w;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (5) @(posedge clock);
    wb(1'b0, CFG_ADDR, 32'h0, q);
    check_val("cfg reset", 32'h1, q);
    wb(1'b1, STATUS_ADDR, 32'hFFFFFFFF, q);
    wb(1'b0, STATUS_ADDR, 32'h0, q);
    check_val("status reset", 32'h0, q);
    wb(1'b0, 4'hC, 32'h0, q);
    check_val("unmapped read", 32'h0, q);
    $display("registers done");
    run(OP_WRITE, SUB_DISABLE, 7'h05, 16'hA55A, 0);
    run(OP_ERASE, SUB_DISABLE, 7'h05, 16'h0, 0);
    run(OP_SPECIAL, SUB_FILL_ALL, 7'h0, 16'h1234, 0);
    run(OP_SPECIAL, SUB_CLEAR_ALL, 7'h0, 16'h0, 0);
    $display("disabled commands done");
    run(OP_SPECIAL, SUB_ENABLE, 7'(rnd()), 16'h0, 0);
    wb(1'b0, STATUS_ADDR, 32'h0, q);
    check_val("enabled flag", 32'h1, q);
    run(OP_SPECIAL, SUB_CLEAR_ALL, 7'(rnd()), 16'h0, P - 30);
    rd(7'(rnd()));
    run(OP_SPECIAL, SUB_FILL_ALL, 7'(rnd()), 16'(rnd()), P - 30);
    rd(7'h00);
    rd(7'(rnd()));
    $display("whole array done");
    for (int k = 0; k < 4; k++)
    begin
      a = (k == 0) ? 7'h00 : (k == 1) ? 7'h3F : 7'(rnd());
      run(OP_WRITE, SUB_DISABLE, a, 16'(rnd()), P - 30);
      rd(a);
    end
    a = 7'(rnd());
    d = 16'(rnd());
    cmd(OP_WRITE, a, d, 1'b1);
    apply(OP_WRITE, SUB_DISABLE, a, d);
    host.close_frame();
    cmd(OP_ERASE, a ^ 7'h01, 16'h0, 1'b0);
    host.poll(en, first, w);
    check_cnt("busy after ignored start", 1, P - 60, w);
    rd(a ^ 7'h01);
    run(OP_ERASE, SUB_DISABLE, a, 16'h0, P - 30);
    rd(a);
    $display("single location done");
    a = 7'(rnd());
    d = 16'(rnd());
    cmd(OP_WRITE, a, d, 1'b1);
    apply(OP_WRITE, SUB_DISABLE, a, d);
    host.close_frame();
    host.tick(P);
    host.poll(en, first, w);
    check_val("late status", 32'h0, {31'h0, en});
    rd(a);
    $display("late poll done");
    wb(1'b1, CFG_ADDR, 32'h0, q);
    word_size_select = 1'b0;
    wb(1'b0, CFG_ADDR, 32'h0, q);
    check_val("cfg byte mode", 32'h0, q);
    for (int k = 0; k < 3; k++)
    begin
      a = (k == 0) ? 7'h7F : 7'(rnd());
      run(OP_WRITE, SUB_DISABLE, a, 16'(rnd()), P - 30);
      rd(a);
      rd(a ^ 7'h01);
    end
    $display("byte mode done");
    run(OP_SPECIAL, SUB_DISABLE, 7'(rnd()), 16'h0, 0);
    wb(1'b0, STATUS_ADDR, 32'h0, q);
    check_val("disabled flag", 32'h0, q);
    run(OP_WRITE, SUB_DISABLE, a, ~exp_word(a), 0);
    run(OP_SPECIAL, SUB_CLEAR_ALL, 7'(rnd()), 16'h0, 0);
    rd(a);
    $display("disable done");
    print_verdict();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge clock);
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
